//--- include/eic_pkg.sv
// eic_pkg: constants and types shared by the interval counter pair.
// assumes a 200 MHz system clock and AXI4-Lite register access.
package eic_pkg;

  // clock rates in MHz; count tick derived from these
  localparam int CLK_MHZ   = 200;
  localparam int COUNT_MHZ = 48;
  localparam int ACC_W     = 8;

  // event source codes for start and stop selection
  localparam int SEL_W          = 3;
  localparam int NUM_EV         = 5;
  localparam logic [2:0] EV_ADC       = 3'h0;
  localparam logic [2:0] EV_TACH_RISE = 3'h1;
  localparam logic [2:0] EV_TACH_FALL = 3'h2;
  localparam logic [2:0] EV_GATE_RISE = 3'h3;
  localparam logic [2:0] EV_GATE_FALL = 3'h4;

  // register byte offsets
  localparam logic [7:0] OFS_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CFG1   = 8'h04;
  localparam logic [7:0] OFS_HOLD0  = 8'h08;
  localparam logic [7:0] OFS_HOLD1  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // config register fields
  localparam int CFG_W        = 8;
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_START_LO = 1;
  localparam int CFG_STOP_LO  = 4;
  localparam int CFG_SCLR_BIT = 7;
  localparam logic [7:0] CFG_RST = 8'h00;

  // scan channel numbers of the two counters
  localparam logic [3:0] SCAN_CH_A = 4'h6;
  localparam logic [3:0] SCAN_CH_B = 4'h7;

  // axi responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // channel state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } eic_state_t;

  // pick one event out of the source vector; unused codes never fire
  function automatic logic eic_pick(input logic [4:0] ev, input logic [2:0] sel);
    eic_pick = (sel < 3'h5) ? ev[sel] : 1'b0;
  endfunction : eic_pick

endpackage : eic_pkg

//--- include/eic_chan_if.sv
// eic_chan_if: config, events and results between top and one channel.
// assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface eic_chan_if #(parameter int CNT_W = 32);
  logic             enable;     // channel enabled
  logic [2:0]       startSel;   // start event code
  logic [2:0]       stopSel;    // stop event code
  logic             selfClear;  // zero between measurements
  logic [4:0]       events;     // one-cycle event pulses
  logic             tick;       // 48 MHz count tick
  logic             readPulse;  // scan took the value
  logic             busy;       // counting in progress
  logic             fresh;      // unread result present
  logic [CNT_W-1:0] hold;       // raw holding register
  logic [CNT_W-1:0] value;      // value for the scan

  modport top (output enable, startSel, stopSel, selfClear, events, tick,
               readPulse, input busy, fresh, hold, value);
  modport chan (input enable, startSel, stopSel, selfClear, events, tick,
                readPulse, output busy, fresh, hold, value);
endinterface : eic_chan_if

//--- verilog/eic_channel.sv
// eic_channel: one start/stop interval counter with holding register.
// assumes event pulses and tick are one cycle wide, clock 200 MHz.
`timescale 1ns/1ps
module eic_channel #(
  parameter int CNT_W = 32
) (
  // system
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  // link to top
  eic_chan_if.chan  cif
);

  eic_pkg::eic_state_t state_r;       // idle or counting
  logic [CNT_W-1:0]    count_r;       // running count
  logic [CNT_W-1:0]    hold_r;        // last finished count
  logic                fresh_r;       // result not yet scanned
  logic                startHit;      // selected start fired
  logic                stopHit;       // selected stop fired
  logic                finish;        // measurement completes now

  // event selection, start and stop chosen independently
  assign startHit = eic_pkg::eic_pick(cif.events, cif.startSel);
  assign stopHit  = eic_pkg::eic_pick(cif.events, cif.stopSel);
  assign finish   = cif.enable && state_r == eic_pkg::ST_RUN && stopHit;

  // sequencer: only run state looks at stop, so a shared edge
  // closes one period and the next must start afresh
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= eic_pkg::ST_IDLE;
      count_r <= '0;
    end else if (ce) begin
      if (!cif.enable) begin
        state_r <= eic_pkg::ST_IDLE;
        count_r <= '0;
      end else begin
        unique case (state_r)
          eic_pkg::ST_IDLE: begin
            if (startHit) begin
              state_r <= eic_pkg::ST_RUN;
              count_r <= CNT_W'(1);
            end
          end
          eic_pkg::ST_RUN: begin
            if (stopHit) begin
              state_r <= eic_pkg::ST_IDLE;
              count_r <= '0;
            end else if (cif.tick) begin
              count_r <= count_r + CNT_W'(1);
            end
          end
        endcase
      end
    end
  end

  // holding register and unread flag; a finish beats a scan read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_r  <= '0;
      fresh_r <= 1'b0;
    end else if (ce) begin
      if (finish) begin
        hold_r  <= count_r;
        fresh_r <= 1'b1;
      end else if (cif.readPulse) begin
        fresh_r <= 1'b0;
      end
    end
  end

  // scan value: zero once read when self clear is set
  assign cif.value = (cif.selfClear && !fresh_r) ? '0 : hold_r;
  assign cif.hold  = hold_r;
  assign cif.fresh = fresh_r;
  assign cif.busy  = (state_r == eic_pkg::ST_RUN);

endmodule : eic_channel

//--- verilog/eic_top.sv
// eic_top: two interval counters, axi4-lite registers, scan output.
// assumes tach, gate, adc done and sample tick synchronous to clock.
//
// Operation
// - two independent channels, 32-bit counts each
// - start event picked from five sources
// - stop event picked independently, same sources
// - counting at 48 MHz begins on start
// - stop latches count, clears, idles
// - holding value sampled at scan rate
// - first channel is scan 6, second 7
// - only enabled channels enter the stream
// - self clear gives zero between results
// - same start/stop edge measures alternate periods
// - interval equals count minus one over 48MHz
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module eic_top #(
  parameter int CNT_W = 32
) (
  // system
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // measured signals
  input  wire logic        tachIn,
  input  wire logic        gateIn,
  input  wire logic        adcDone,
  // scan interface
  input  wire logic        sampleTick,
  input  wire logic        scanReady,
  output logic             scanValid,
  output logic [3:0]       scanChan,
  output logic [CNT_W-1:0] scanData,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---- channel links ----
  eic_chan_if #(.CNT_W(CNT_W)) chA ();   // first counter
  eic_chan_if #(.CNT_W(CNT_W)) chB ();   // second counter

  // ---- count tick generation ----
  logic [eic_pkg::ACC_W-1:0] acc_r;      // phase accumulator
  logic [eic_pkg::ACC_W-1:0] accSum;     // accumulator plus step
  logic                      accWrap;    // sum passed clock rate
  logic                      tick_r;     // one-cycle 48 MHz tick

  // fractional divider: 48 ticks per 200 clocks, evenly spread
  assign accSum  = acc_r + eic_pkg::ACC_W'(eic_pkg::COUNT_MHZ);
  assign accWrap = accSum >= eic_pkg::ACC_W'(eic_pkg::CLK_MHZ);

  // accumulator and tick flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      acc_r  <= accWrap ? accSum - eic_pkg::ACC_W'(eic_pkg::CLK_MHZ) : accSum;
      tick_r <= accWrap;
    end
  end

  // ---- edge detection ----
  logic tachPrev_r;                      // tach last cycle
  logic gatePrev_r;                      // gate last cycle
  logic [4:0] events;                    // event pulses by code

  // previous levels for edge compare
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tachPrev_r <= 1'b0;
      gatePrev_r <= 1'b0;
    end else if (ce) begin
      tachPrev_r <= tachIn;
      gatePrev_r <= gateIn;
    end
  end

  // the five sources, indexed by their select code
  assign events[eic_pkg::EV_ADC]       = adcDone;
  assign events[eic_pkg::EV_TACH_RISE] = tachIn && !tachPrev_r;
  assign events[eic_pkg::EV_TACH_FALL] = !tachIn && tachPrev_r;
  assign events[eic_pkg::EV_GATE_RISE] = gateIn && !gatePrev_r;
  assign events[eic_pkg::EV_GATE_FALL] = !gateIn && gatePrev_r;

  // ---- configuration registers ----
  logic [eic_pkg::CFG_W-1:0] cfgA_r;     // first channel config
  logic [eic_pkg::CFG_W-1:0] cfgB_r;     // second channel config

  // drive config and shared signals to both channels
  assign chA.enable    = cfgA_r[eic_pkg::CFG_EN_BIT];
  assign chA.startSel  = cfgA_r[eic_pkg::CFG_START_LO +: eic_pkg::SEL_W];
  assign chA.stopSel   = cfgA_r[eic_pkg::CFG_STOP_LO +: eic_pkg::SEL_W];
  assign chA.selfClear = cfgA_r[eic_pkg::CFG_SCLR_BIT];
  assign chA.events    = events;
  assign chA.tick      = tick_r;
  assign chB.enable    = cfgB_r[eic_pkg::CFG_EN_BIT];
  assign chB.startSel  = cfgB_r[eic_pkg::CFG_START_LO +: eic_pkg::SEL_W];
  assign chB.stopSel   = cfgB_r[eic_pkg::CFG_STOP_LO +: eic_pkg::SEL_W];
  assign chB.selfClear = cfgB_r[eic_pkg::CFG_SCLR_BIT];
  assign chB.events    = events;
  assign chB.tick      = tick_r;

  // ---- the two counters ----
  eic_channel #(.CNT_W(CNT_W)) uChanA (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .cif   (chA)
  );

  eic_channel #(.CNT_W(CNT_W)) uChanB (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .cif   (chB)
  );

  // ---- scan output ----
  logic             outValid_r;          // scan word on offer
  logic [3:0]       outChan_r;           // its channel number
  logic [CNT_W-1:0] outData_r;           // its value
  logic             pendB_r;             // second word still due
  logic [CNT_W-1:0] snapB_r;             // second value snapshot
  logic             scanTake;            // sample accepted now
  logic             scanMove;            // consumer took a word

  // a tick arriving while words are still queued is dropped,
  // since nothing beyond one scan is buffered
  assign scanTake = sampleTick && !outValid_r && (chA.enable || chB.enable);
  assign scanMove = outValid_r && scanReady;

  // both values captured at the same tick so they stay aligned
  assign chA.readPulse = scanTake && chA.enable;
  assign chB.readPulse = scanTake && chB.enable;

  // scan word sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outValid_r <= 1'b0;
      outChan_r  <= 4'h0;
      outData_r  <= '0;
      pendB_r    <= 1'b0;
      snapB_r    <= '0;
    end else if (ce) begin
      if (scanTake) begin
        outValid_r <= 1'b1;
        outChan_r  <= chA.enable ? eic_pkg::SCAN_CH_A : eic_pkg::SCAN_CH_B;
        outData_r  <= chA.enable ? chA.value : chB.value;
        pendB_r    <= chA.enable && chB.enable;
        snapB_r    <= chB.value;
      end else if (scanMove) begin
        if (pendB_r) begin
          outChan_r <= eic_pkg::SCAN_CH_B;
          outData_r <= snapB_r;
          pendB_r   <= 1'b0;
        end else begin
          outValid_r <= 1'b0;
        end
      end
    end
  end

  assign scanValid = outValid_r;
  assign scanChan  = outChan_r;
  assign scanData  = outData_r;

  // ---- axi4-lite write path ----
  logic        awPend_r;                 // address held
  logic [7:0]  awAddr_r;                 // held address
  logic        wPend_r;                  // data held
  logic [31:0] wData_r;                  // held data
  logic [3:0]  wStrb_r;                  // held strobes
  logic        bValid_r;                 // response on offer
  logic [1:0]  bResp_r;                  // response code
  logic        wrDo;                     // perform write now
  logic        wrHitA;                   // write to first config
  logic        wrHitB;                   // write to second config
  logic        wrOk;                     // address is writable

  // address and data taken in either order, one write at a time
  assign s_axi_awready = !awPend_r && !bValid_r;
  assign s_axi_wready  = !wPend_r && !bValid_r;
  assign wrDo          = awPend_r && wPend_r && !bValid_r;
  assign wrHitA        = awAddr_r == eic_pkg::OFS_CFG0;
  assign wrHitB        = awAddr_r == eic_pkg::OFS_CFG1;
  assign wrOk          = wrHitA || wrHitB;

  // capture of address and data channels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awPend_r <= 1'b0;
      awAddr_r <= 8'h00;
      wPend_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrDo) begin
        awPend_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrDo) begin
        wPend_r <= 1'b0;
      end
    end
  end

  // config update on lane 0, then the write response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfgA_r   <= eic_pkg::CFG_RST;
      cfgB_r   <= eic_pkg::CFG_RST;
      bValid_r <= 1'b0;
      bResp_r  <= eic_pkg::RESP_OK;
    end else if (ce) begin
      if (wrDo) begin
        if (wrHitA && wStrb_r[0]) begin
          cfgA_r <= wData_r[eic_pkg::CFG_W-1:0];
        end
        if (wrHitB && wStrb_r[0]) begin
          cfgB_r <= wData_r[eic_pkg::CFG_W-1:0];
        end
        bValid_r <= 1'b1;
        bResp_r  <= wrOk ? eic_pkg::RESP_OK : eic_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp  = bResp_r;

  // ---- axi4-lite read path ----
  logic        rValid_r;                 // read data on offer
  logic [31:0] rData_r;                  // read data
  logic [1:0]  rResp_r;                  // read response
  logic [31:0] rdMux;                    // decoded read value
  logic        rdOk;                     // address is mapped
  logic [31:0] statusWord;               // live channel state

  // status: busy bits then unread-result bits
  assign statusWord = {28'h0000000, chB.fresh, chA.fresh, chB.busy, chA.busy};

  // one read at a time; address taken only when no data pending
  assign s_axi_arready = !rValid_r;
  assign rdOk = s_axi_araddr == eic_pkg::OFS_CFG0  || s_axi_araddr == eic_pkg::OFS_CFG1 ||
                s_axi_araddr == eic_pkg::OFS_HOLD0 || s_axi_araddr == eic_pkg::OFS_HOLD1 ||
                s_axi_araddr == eic_pkg::OFS_STATUS;
  assign rdMux =
    (s_axi_araddr == eic_pkg::OFS_CFG0)  ? {24'h000000, cfgA_r} :
    (s_axi_araddr == eic_pkg::OFS_CFG1)  ? {24'h000000, cfgB_r} :
    (s_axi_araddr == eic_pkg::OFS_HOLD0) ? 32'(chA.hold) :
    (s_axi_araddr == eic_pkg::OFS_HOLD1) ? 32'(chB.hold) :
    (s_axi_araddr == eic_pkg::OFS_STATUS) ? statusWord : 32'h0000_0000;

  // read data register; register reads have no side effects
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= eic_pkg::RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rValid_r <= 1'b1;
        rData_r  <= rdMux;
        rResp_r  <= rdOk ? eic_pkg::RESP_OK : eic_pkg::RESP_ERR;
      end else if (s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata  = rData_r;
  assign s_axi_rresp  = rResp_r;

endmodule : eic_top

//--- verification/eic_top_asserts.sv
// eic_top_asserts: port-level checks of the interval counter pair.
// assumes ce stays high; bound onto every eic_top instance.
`timescale 1ns/1ps
module eic_top_asserts #(
  parameter int CNT_W = 32
) (
  // system
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             ce,
  // scan
  input wire logic             sampleTick,
  input wire logic             scanReady,
  input wire logic             scanValid,
  input wire logic [3:0]       scanChan,
  input wire logic [CNT_W-1:0] scanData,
  // axi handshakes
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_SCAN_CHAN: assert property (scanValid |-> scanChan inside {4'h6, 4'h7})
    else $error("scan word with a foreign channel number");
  AST_SCAN_HOLD: assert property (scanValid && !scanReady |=>
    scanValid && $stable(scanChan) && $stable(scanData))
    else $error("scan word changed while stalled");
  AST_SCAN_LAST: assert property (scanValid && scanReady && scanChan == 4'h7 |=>
    !scanValid)
    else $error("word offered after the second channel");
  AST_SCAN_CAUSE: assert property ($rose(scanValid) |-> $past(sampleTick))
    else $error("scan word without a sample strobe");
  // reset itself is the cause here, so it must not disable the check
  AST_RST_IDLE: assert property (disable iff (1'b0) !rst_n && ce |=>
    !scanValid && !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
    else $error("outputs not idle after reset");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after address and data");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while a response is pending");
endmodule : eic_top_asserts

bind eic_top eic_top_asserts #(.CNT_W(CNT_W)) chk_u (
  .clock, .rst_n, .ce, .sampleTick, .scanReady, .scanValid, .scanChan, .scanData,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

//--- verification/eic_sig_model.sv
// eic_sig_model: tachometer, gate and a/d completion sources.
// assumes half periods of at least two clocks, set by the bench.
`timescale 1ns/1ps
module eic_sig_model (
  // system
  input  wire logic       clock,
  input  wire logic       rst_n,
  // half periods in clocks
  input  wire logic [7:0] tachHalf,
  input  wire logic [7:0] gateHalf,
  // generated lines
  output logic            tachIn,
  output logic            gateIn,
  output logic            adcDone
);
  logic [7:0] tachCnt_r; // clocks into tach half
  logic [7:0] gateCnt_r; // clocks into gate half
  logic       tachFlip;  // tach level turns
  logic       gateFlip;  // gate level turns
  // >= so a shortened half period never wraps the count
  assign tachFlip = tachCnt_r >= tachHalf - 8'h01;
  assign gateFlip = gateCnt_r >= gateHalf - 8'h01;

  // square waves; a/d completion marks each tach rise so its phase is known
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tachCnt_r <= 8'h00;
      gateCnt_r <= 8'h00;
      tachIn    <= 1'b0;
      gateIn    <= 1'b0;
      adcDone   <= 1'b0;
    end else begin
      tachCnt_r <= tachFlip ? 8'h00 : tachCnt_r + 8'h01;
      gateCnt_r <= gateFlip ? 8'h00 : gateCnt_r + 8'h01;
      tachIn    <= tachIn ^ tachFlip;
      gateIn    <= gateIn ^ gateFlip;
      adcDone   <= tachFlip && !tachIn; // one-cycle pulse
    end
  end
endmodule : eic_sig_model

//--- verification/testbench.sv
// testbench: drives the counter pair over axi and reads the scan port.
// assumes eic_top, eic_sig_model and the bound checker are compiled.
`timescale 1ns/1ps
module testbench;
  // clock, reset, strobes
  logic        clock, rst_n, ce, sampleTick, scanReady, tachIn, gateIn, adcDone;
  logic [7:0]  tachHalf, gateHalf;
  // scan outputs
  logic        scanValid;
  logic [3:0]  scanChan;
  logic [31:0] scanData;
  // axi master side
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_total, n_tests;
  // start and stop codes per pass; adc done never at both ends
  logic [2:0]  startTab [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h2, 3'h1};
  logic [2:0]  stopTab  [7] = '{3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h0, 3'h1};

  eic_top #(.CNT_W(32)) dut_u (
    .clock, .rst_n, .ce, .tachIn, .gateIn, .adcDone, .sampleTick, .scanReady,
    .scanValid, .scanChan, .scanData, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  eic_sig_model sig_u (.clock, .rst_n, .tachHalf, .gateHalf, .tachIn, .gateIn, .adcDone);

  // 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // a wait that ran out ends the run
  task automatic hang;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // counts only pin down to one tick, since the tick phase is unseen
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    n_tests++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // handshakes judged at the falling edge, acted on at the next rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    bit awT, wT, bT;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge clock);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      if (bT) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 100) hang();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    bit arT, rT;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge clock);
      arT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (arT) s_axi_arvalid <= 1'b0;
      if (rT) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 100) hang();
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd_chk

  // one strobe, then one word per enabled channel with a random stall
  task automatic scan_get(input bit two, output logic [31:0] a, output logic [31:0] b);
    int n, k;
    @(posedge clock);
    sampleTick <= 1'b1;
    @(posedge clock);
    sampleTick <= 1'b0;
    for (n = 0; n <= int'(two); n++) begin
      for (k = 0; k < 20; k++) begin
        @(negedge clock);
        if ((scanValid && scanReady) === 1'b1) break;
        @(posedge clock);
        scanReady <= 1'b1;
      end
      if (k == 20) hang();
      chk({28'h0, scanChan}, 32'h6 + n);
      if (n == 0) a = scanData;
      else b = scanData;
      @(posedge clock);
      scanReady <= 1'($urandom % 2);
    end
    @(negedge clock);
    chk({31'h0, scanValid}, 32'h0);
  endtask : scan_get

  // clocks from start to stop for pass p
  function automatic int span(int p);
    if (p == 2 || p == 3) return gateHalf;
    if (p == 6) return 2 * tachHalf;
    return tachHalf;
  endfunction : span

  initial begin
    logic [31:0] a1, b1, a2, b2, rd;
    logic [1:0]  rs;
    logic [7:0]  cfg;
    bit          sclr, enB;
    int          i, n, lo, hi;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'hF694875D));
    {rst_n, sampleTick, scanReady, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    tachHalf = 8'h14;
    gateHalf = 8'h14;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) rd_chk(8'(i << 2), 32'h0, eic_pkg::RESP_OK);
    rd_chk(8'h14, 32'h0, eic_pkg::RESP_ERR);
    axi_wr(eic_pkg::OFS_HOLD0, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, eic_pkg::RESP_ERR});
    for (i = 0; i < 7; i++) begin
      axi_wr(eic_pkg::OFS_CFG0, 32'h0, rs);
      axi_wr(eic_pkg::OFS_CFG1, 32'h0, rs);
      tachHalf <= 8'h14 + 8'($urandom % 64);
      gateHalf <= 8'h14 + 8'($urandom % 64);
      sclr = 1'($urandom % 2);
      enB = (i != 1);
      cfg = {sclr, stopTab[i], startTab[i], 1'b1};
      // let both waves settle on the new periods
      repeat (200) @(posedge clock);
      axi_wr(eic_pkg::OFS_CFG0, {24'h0, cfg}, rs);
      axi_wr(eic_pkg::OFS_CFG1, {24'h0, cfg & {7'h7F, enB}}, rs);
      // early strobe flushes results left from the last pass
      scan_get(enB, a1, b1);
      rd_chk(eic_pkg::OFS_CFG0, {24'h0, cfg}, eic_pkg::RESP_OK);
      for (n = 0; n < 400; n++) begin
        axi_rd(eic_pkg::OFS_STATUS, rd, rs);
        if ((rd[3:2] & {enB, 1'b1}) === {enB, 1'b1}) break;
      end
      if (n == 400) hang();
      scan_get(enB, a1, b1);
      scan_get(enB, a2, b2);
      lo = 1 + ((span(i) - 1) * eic_pkg::COUNT_MHZ) / eic_pkg::CLK_MHZ;
      hi = 2 + (span(i) * eic_pkg::COUNT_MHZ) / eic_pkg::CLK_MHZ;
      chk_rng(a1, lo, hi);
      if (enB) chk_rng(b1, lo, hi);
      chk(a2, sclr ? 32'h0 : a1);
      if (enB) chk(b2, sclr ? 32'h0 : b1);
      $display("pass %0d done, start %0d stop %0d", i, startTab[i], stopTab[i]);
    end
    wrap_up();
  end
endmodule : testbench
